// *** bench/pms_status_core_bench.sv ***
// bench for the mode and interrupt status block
`timescale 1ns/1ps
`default_nettype none
module pms_status_core_bench;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got, rdata_ns;
  logic [1:0]  bresp, rresp, sw_int_req;
  logic [5:0]  hw_int_req, eic_level;
  logic [63:0] probe_addr;
  logic [7:0]  evs[4];
  logic [31:0] exp_st[4];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  pms_pkg::pms_seg_t      miss_seg;
  pms_pkg::pms_core_ev_t  core_ev;
  pms_pkg::pms_core_out_t core_out, out_ns;

  pms_status_core dut_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .core_ev(core_ev), .hw_int_req(hw_int_req),
    .sw_int_req(sw_int_req), .eic_level(eic_level),
    .miss_seg(miss_seg), .probe_addr(probe_addr),
    .core_out(core_out));

  // twin without supervisor mode, same stimulus, read data watched
  pms_status_core #(.SUPERVISOR_PRESENT(1'b0)) dut_ns_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(),
    .wdata(wdata), .wstrb(wstrb), .bvalid(), .bready(bready), .bresp(),
    .arvalid(arvalid), .arready(), .araddr(araddr), .arprot(3'h0),
    .rvalid(), .rready(rready), .rdata(rdata_ns), .rresp(),
    .core_ev(core_ev), .hw_int_req(hw_int_req),
    .sw_int_req(sw_int_req), .eic_level(eic_level),
    .miss_seg(miss_seg), .probe_addr(probe_addr),
    .core_out(out_ns));

  // clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic c1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : c1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    // each channel released at the edge that takes it
    do begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
      end
      if (wready) begin
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, (a > 8'h04) ? 32'h2 : 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    araddr  <= a;
    // address released when taken, data taken at the rvalid edge
    do begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
      end
    end while (!rvalid);
    rready <= 1'b0;
    got = rdata;
    chk({30'h0, rresp}, {30'h0, r});
  endtask : rd

  task automatic rs(input logic [31:0] e);
    rd(8'h00, 2'h0);
    chk(got, e);
  endtask : rs

  task automatic ev(input logic [7:0] e);
    @(posedge aclk);
    core_ev <= pms_pkg::pms_core_ev_t'(e);
    @(posedge aclk);
    core_ev <= '0;
    repeat (2) @(negedge aclk);
  endtask : ev

  task automatic lv(input logic [5:0] h, input logic [1:0] s,
                    input logic [5:0] l);
    @(posedge aclk);
    hw_int_req <= h;
    sw_int_req <= s;
    eic_level  <= l;
    repeat (3) @(negedge aclk);
  endtask : lv

  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, arvalid, bready, rready} = '0;
    wstrb = 4'hf;
    {awaddr, araddr, wdata, hw_int_req} = '0;
    {sw_int_req, eic_level, probe_addr} = '0;
    core_ev = '0;
    miss_seg = pms_pkg::PMS_SEG_USER;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rs(32'h0040_0004); // reset word
    c1(core_out.exception_return_instr_to_error, 1'b1); // error return
    rd(8'h08, 2'h2);
    chk(got, 32'h0);
    wr(8'h08, 32'hffff_ffff);
    wr(8'h00, 32'h0038_fff1);
    rs(32'h0000_fff1); // raised flags dropped
    chk({30'h0, core_out.eff_mode}, 32'h2); // user mode
    c1(core_out.ops64_ok, 1'b1); // wide user ops
    for (int s = 0; s < 3; s++) begin
      @(posedge aclk);
      miss_seg <= pms_pkg::pms_seg_t'(s);
      repeat (2) @(negedge aclk);
      chk({30'h0, core_out.refill_vec}, 32'h1);
      c1(core_out.seg_wide_ok, 1'b1);
    end
    wr(8'h00, 32'h0000_ff11);
    chk({30'h0, core_out.refill_vec}, 32'h0); // ordinary
    c1(core_out.seg_wide_ok, 1'b0); // narrow user
    c1(core_out.ops64_ok, 1'b0); // no wide ops
    wr(8'h00, 32'h0000_fff1);
    lv(6'h01, 2'h0, 6'h00);
    c1(core_out.int_signal, 1'b1); // enabled
    ev(8'h02);
    rs(32'h0000_fff0); // disable alone
    c1(core_out.int_signal, 1'b0); // disabled
    ev(8'h01);
    c1(core_out.int_signal, 1'b1); // enable alone
    lv(6'h00, 2'h1, 6'h00);
    c1(core_out.int_signal, 1'b1); // soft request 0
    wr(8'h00, 32'h0000_fef1);
    c1(core_out.int_signal, 1'b0); // soft mask 0 off
    lv(6'h00, 2'h2, 6'h00);
    c1(core_out.int_signal, 1'b1); // soft mask 1 on
    ev(8'he0);
    rs(32'h0000_fef3); // exception level
    c1(core_out.int_signal, 1'b0); // blocked
    c1(core_out.kernel_mode, 1'b1); // kernel
    c1(core_out.ctx_update_en, 1'b0); // context kept
    chk({30'h0, core_out.refill_vec}, 32'h3); // general
    ev(8'h04);
    rs(32'h0000_fef1);
    // multi match, soft, nmi and cache error entries
    evs = '{8'h08, 8'h90, 8'hb0, 8'ha0};
    exp_st = '{32'h0020_fef1, 32'h0050_fef5, 32'h0048_fef5,
               32'h0000_fef5};
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h0000_fef1);
      ev(evs[i]);
      rs(exp_st[i]);
    end
    c1(core_out.int_signal, 1'b0); // blocked
    c1(core_out.exception_return_instr_to_error, 1'b1); // error return
    c1(core_out.kuseg_bypass, 1'b1); // low window
    @(posedge aclk);
    probe_addr <= 64'h0000_0000_2000_0000;
    repeat (2) @(negedge aclk);
    c1(core_out.kuseg_bypass, 1'b0); // window end
    wr(8'h04, 32'h0000_0001);
    c1(core_out.eic_mode, 1'b1); // external mode on
    wr(8'h00, 32'h0000_4301);
    lv(6'h00, 2'h3, 6'h10);
    rs(32'h0000_4301); // masks writable
    c1(core_out.int_signal, 1'b0); // equal level
    lv(6'h00, 2'h3, 6'h11);
    c1(core_out.int_signal, 1'b1); // higher level
    wr(8'h00, 32'h0000_0018);
    rs(32'h0000_0018); // reserved base code kept
    chk(rdata_ns, 32'h0000_0010); // bit three reads zero
    chk({30'h0, core_out.eff_mode}, 32'h0); // runs as kernel
    chk({30'h0, out_ns.eff_mode}, 32'h2); // user base mode
    wstrb <= 4'h2;
    wr(8'h00, 32'hffff_ffff);
    wstrb <= 4'hf;
    rs(32'h0000_ff18); // one byte lane, masks set
    summarize();
  end
endmodule : pms_status_core_bench
`default_nettype wire

// *** core/pms_axil_slave.sv ***
// module: axi4-lite slave handshake for the status block registers
`timescale 1ns/1ps
`default_nettype none
module pms_axil_slave (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [7:0]          awaddr,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output pms_pkg::pms_regwr_t      wr,
  input  wire logic                wr_err,
  input  wire logic [31:0]         rd_word,
  input  wire logic                rd_err
);

  typedef struct packed {
    logic               awready;
    logic               wready;
    logic               arready;
    logic               aw_held;
    logic               w_held;
    pms_pkg::pms_regwr_t req;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } pms_slv_st_t;

  pms_slv_st_t q;
  pms_slv_st_t d;

  // address and data taken in either order, write fires once both held
  always_comb begin
    d = q;
    d.req.valid = 1'b0;
    if (awvalid && q.awready) begin
      d.aw_held  = 1'b1;
      d.req.addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_held   = 1'b1;
      d.req.data = wdata;
      d.req.strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.req.valid = 1'b1;
      d.aw_held   = 1'b0;
      d.w_held    = 1'b0;
    end
    if (q.req.valid) begin
      d.bvalid = 1'b1;
      d.bresp  = wr_err ? pms_pkg::PMS_RESP_SLVERR : pms_pkg::PMS_RESP_OKAY;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_word;
      d.rresp  = rd_err ? pms_pkg::PMS_RESP_SLVERR : pms_pkg::PMS_RESP_OKAY;
    end
    d.awready = !d.aw_held && !d.req.valid && !q.req.valid && !d.bvalid;
    d.wready  = !d.w_held && !d.req.valid && !q.req.valid && !d.bvalid;
    d.arready = !d.rvalid;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready  = q.wready;
  assign arready = q.arready;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;
  assign wr      = q.req;

endmodule : pms_axil_slave
`default_nettype wire

// *** core/pms_int_gate.sv ***
// module: interrupt request gating by masks, priority level and levels
`timescale 1ns/1ps
`default_nettype none
module pms_int_gate (
  input  wire pms_pkg::pms_status_t st,
  input  wire logic                 eic_mode,
  input  wire logic [5:0]           hw_int_req,
  input  wire logic [1:0]           sw_int_req,
  input  wire logic [5:0]           eic_level,
  output logic                      int_pend
);

  logic mask_hit;
  logic prio_hit;

  assign mask_hit = |(hw_int_req & st.hw_mask) | |(sw_int_req & st.sw_mask);
  assign prio_hit = eic_level > st.hw_mask;

  assign int_pend = st.ie && !st.exception_level && !st.error_level &&
                    (eic_mode ? prio_hit : mask_hit);

endmodule : pms_int_gate
`default_nettype wire

// *** core/pms_pkg.sv ***
// package: constants and carriers of the mode and interrupt status block
`default_nettype none
package pms_pkg;

  // register map
  localparam int unsigned PMS_ADDR_W     = 8;
  localparam logic [7:0]  PMS_STATUS_OFF = 8'h00;
  localparam logic [7:0]  PMS_CTRL_OFF   = 8'h04;

  // status field positions
  localparam int unsigned PMS_BEV_POS  = 22;
  localparam int unsigned PMS_MM_POS   = 21;
  localparam int unsigned PMS_SR_POS   = 20;
  localparam int unsigned PMS_NMI_POS  = 19;
  localparam int unsigned PMS_HWM_LO   = 10;
  localparam int unsigned PMS_SWM_LO   = 8;
  localparam int unsigned PMS_KX_POS   = 7;
  localparam int unsigned PMS_SX_POS   = 6;
  localparam int unsigned PMS_UX_POS   = 5;
  localparam int unsigned PMS_MODE_LO  = 3;
  localparam int unsigned PMS_ERL_POS  = 2;
  localparam int unsigned PMS_EXL_POS  = 1;
  localparam int unsigned PMS_IE_POS   = 0;
  localparam int unsigned PMS_EIC_POS  = 0;

  // reset values
  localparam logic        PMS_BEV_RST  = 1'b1;
  localparam logic        PMS_ERL_RST  = 1'b1;
  localparam logic        PMS_FLAG_RST = 1'b0;
  localparam logic        PMS_CTL_RST  = 1'b0;
  localparam logic [5:0]  PMS_HWM_RST  = 6'h00;
  localparam logic [1:0]  PMS_SWM_RST  = 2'h0;
  localparam logic [1:0]  PMS_MODE_RST = 2'h0;

  // bus answers and the kuseg window left unmapped at error level
  localparam logic [1:0]  PMS_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PMS_RESP_SLVERR = 2'h2;
  localparam logic [63:0] PMS_KUSEG_BYPASS_BYTES = 64'h0000_0000_2000_0000;

  typedef enum logic [1:0] {
    PMS_MODE_KERNEL = 2'h0,
    PMS_MODE_SUPER  = 2'h1,
    PMS_MODE_USER   = 2'h2,
    PMS_MODE_RSVD   = 2'h3
  } pms_mode_t;

  typedef enum logic [2:0] {
    PMS_EXC_RESET   = 3'h0,
    PMS_EXC_SOFT    = 3'h1,
    PMS_EXC_NMI     = 3'h3,
    PMS_EXC_CACHE   = 3'h2,
    PMS_EXC_GENERAL = 3'h6
  } pms_exc_kind_t;

  typedef enum logic [1:0] {
    PMS_SEG_KERNEL = 2'h0,
    PMS_SEG_SUPER  = 2'h1,
    PMS_SEG_USER   = 2'h2
  } pms_seg_t;

  typedef enum logic [1:0] {
    PMS_REFILL_ORDINARY = 2'h0,
    PMS_REFILL_EXTENDED = 2'h1,
    PMS_REFILL_GENERAL  = 2'h3
  } pms_refill_t;

  typedef struct packed {
    logic       bootstrap_vector_select;
    logic       mm;
    logic       sr;
    logic       nmi;
    logic [5:0] hw_mask;
    logic [1:0] sw_mask;
    logic       kx;
    logic       sx;
    logic       ux;
    logic [1:0] mode;
    logic       error_level;
    logic       exception_level;
    logic       ie;
  } pms_status_t;

  typedef struct packed {
    logic          exc_take;
    pms_exc_kind_t exc_kind;
    logic          multi_match;
    logic          exception_return_instr;
    logic          di;
    logic          ei;
  } pms_core_ev_t;

  typedef struct packed {
    logic        int_signal;
    logic        kernel_mode;
    pms_mode_t   eff_mode;
    logic        ops64_ok;
    logic        seg_wide_ok;
    pms_refill_t refill_vec;
    logic        exception_return_instr_to_error;
    logic        ctx_update_en;
    logic        kuseg_bypass;
    logic        eic_mode;
  } pms_core_out_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } pms_regwr_t;

  // status fields packed into the bus word, upper bits read zero
  function automatic logic [31:0] pms_pack(input pms_status_t s);
    pms_pack = {9'h000, s.bootstrap_vector_select, s.mm, s.sr, s.nmi, 3'h0, s.hw_mask,
                s.sw_mask, s.kx, s.sx, s.ux, s.mode, s.error_level, s.exception_level, s.ie};
  endfunction : pms_pack

endpackage : pms_pkg
`default_nettype wire

// *** core/pms_status_core.sv ***
// module: privileged mode and interrupt status register, bits 22..0
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pms_status_core #(
  parameter bit          SUPERVISOR_PRESENT = 1'b1,
  parameter int unsigned VA_W               = 64
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [7:0]            awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [7:0]            araddr,
  input  wire logic [2:0]            arprot,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  input  wire pms_pkg::pms_core_ev_t core_ev,
  input  wire logic [5:0]            hw_int_req,
  input  wire logic [1:0]            sw_int_req,
  input  wire logic [5:0]            eic_level,
  input  wire pms_pkg::pms_seg_t     miss_seg,
  input  wire logic [VA_W-1:0]       probe_addr,
  output pms_pkg::pms_core_out_t     core_out
);

  typedef struct packed {
    pms_pkg::pms_status_t   st;
    logic                   eic_mode;
    pms_pkg::pms_core_out_t out;
  } pms_top_st_t;

  pms_top_st_t         q;
  pms_top_st_t         d;
  pms_pkg::pms_regwr_t wr;
  logic                wr_err;
  logic [31:0]         rd_word;
  logic                rd_err;
  logic [31:0]         stat_word;
  logic [31:0]         wr_word;
  logic                int_pend;
  logic                seg_wide;
  logic [7:0]          rd_aligned;
  logic [7:0]          wr_aligned;
  logic                prot_unused;

  // protection bits carry no meaning for this register set
  assign prot_unused = ^{awprot, arprot};

  pms_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wr      (wr),
    .wr_err  (wr_err),
    .rd_word (rd_word),
    .rd_err  (rd_err)
  );

  // read decode on the word-aligned address, unmapped answers slverr
  assign stat_word  = pms_pkg::pms_pack(q.st);
  assign rd_aligned = {araddr[7:2], 2'b00};
  assign wr_aligned = {wr.addr[7:2], 2'b00};
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    if (rd_aligned == pms_pkg::PMS_STATUS_OFF) begin
      rd_word = stat_word;
    end else if (rd_aligned == pms_pkg::PMS_CTRL_OFF) begin
      rd_word[pms_pkg::PMS_EIC_POS] = q.eic_mode;
    end else begin
      rd_err = 1'b1;
    end
  end
  assign wr_err = (wr_aligned != pms_pkg::PMS_STATUS_OFF) &&
                  (wr_aligned != pms_pkg::PMS_CTRL_OFF);

  // byte-lane merge of a status write over the current word
  always_comb begin
    wr_word = stat_word;
    for (int i = 0; i < 4; i++) begin
      if (wr.strb[i]) begin
        wr_word[i*8 +: 8] = wr.data[i*8 +: 8];
      end
    end
  end

  // next status: bus write, then instructions, then hardware events
  always_comb begin
    d = q;
    if (wr.valid && wr_aligned == pms_pkg::PMS_STATUS_OFF) begin
      d.st.bootstrap_vector_select     = wr_word[pms_pkg::PMS_BEV_POS];
      d.st.mm      = q.st.mm  & wr_word[pms_pkg::PMS_MM_POS];
      d.st.sr      = q.st.sr  & wr_word[pms_pkg::PMS_SR_POS];
      d.st.nmi     = q.st.nmi & wr_word[pms_pkg::PMS_NMI_POS];
      d.st.hw_mask = wr_word[pms_pkg::PMS_HWM_LO +: 6];
      d.st.sw_mask = wr_word[pms_pkg::PMS_SWM_LO +: 2];
      d.st.kx      = wr_word[pms_pkg::PMS_KX_POS];
      d.st.sx      = wr_word[pms_pkg::PMS_SX_POS];
      d.st.ux      = wr_word[pms_pkg::PMS_UX_POS];
      d.st.mode[1] = wr_word[pms_pkg::PMS_MODE_LO + 1];
      // low mode bit only with supervisor
      d.st.mode[0] = SUPERVISOR_PRESENT ?
                     wr_word[pms_pkg::PMS_MODE_LO] : 1'b0;
      d.st.error_level     = wr_word[pms_pkg::PMS_ERL_POS];
      d.st.exception_level     = wr_word[pms_pkg::PMS_EXL_POS];
      d.st.ie      = wr_word[pms_pkg::PMS_IE_POS];
    end
    if (wr.valid && wr_aligned == pms_pkg::PMS_CTRL_OFF &&
        wr.strb[0]) begin
      d.eic_mode = wr.data[pms_pkg::PMS_EIC_POS];
    end
    if (core_ev.di) begin
      d.st.ie = 1'b0;
    end else if (core_ev.ei) begin
      d.st.ie = 1'b1;
    end
    if (core_ev.exception_return_instr) begin
      if (q.st.error_level) begin
        d.st.error_level = 1'b0;
      end else begin
        d.st.exception_level = 1'b0;
      end
    end
    if (core_ev.multi_match) begin
      d.st.mm = 1'b1;
    end
    if (core_ev.exc_take) begin
      case (core_ev.exc_kind)
        pms_pkg::PMS_EXC_RESET: begin
          d.st.bootstrap_vector_select = 1'b1;
          d.st.error_level = 1'b1;
          d.st.sr  = 1'b0;
          d.st.nmi = 1'b0;
        end
        pms_pkg::PMS_EXC_SOFT: begin
          d.st.bootstrap_vector_select = 1'b1;
          d.st.error_level = 1'b1;
          d.st.sr  = 1'b1;
          d.st.nmi = 1'b0;
        end
        pms_pkg::PMS_EXC_NMI: begin
          d.st.bootstrap_vector_select = 1'b1;
          d.st.error_level = 1'b1;
          d.st.sr  = 1'b0;
          d.st.nmi = 1'b1;
        end
        pms_pkg::PMS_EXC_CACHE: begin
          d.st.error_level = 1'b1;
        end
        default: begin
          d.st.exception_level = 1'b1;
        end
      endcase
    end
    d.out = derive(d.st, d.eic_mode, int_pend, seg_wide);
  end

  // segment enable for the missing reference
  always_comb begin
    case (miss_seg)
      pms_pkg::PMS_SEG_KERNEL: seg_wide = d.st.kx;
      pms_pkg::PMS_SEG_SUPER:  seg_wide = d.st.sx;
      default:                 seg_wide = d.st.ux;
    endcase
  end

  pms_int_gate u_gate (
    .st         (d.st),
    .eic_mode   (d.eic_mode),
    .hw_int_req (hw_int_req),
    .sw_int_req (sw_int_req),
    .eic_level  (eic_level),
    .int_pend   (int_pend)
  );

  // decoded outputs, registered together with the status they follow
  function automatic pms_pkg::pms_core_out_t derive(
    input pms_pkg::pms_status_t s,
    input logic                 external_interrupt_ctrl_mode,
    input logic                 pend,
    input logic                 wide
  );
    pms_pkg::pms_core_out_t o;
    pms_pkg::pms_mode_t     base;
    o    = '0;
    base = pms_pkg::pms_mode_t'(s.mode);
    // reserved base encoding runs as kernel
    if (base == pms_pkg::PMS_MODE_RSVD) begin
      base = pms_pkg::PMS_MODE_KERNEL;
    end
    o.eff_mode      = (s.exception_level || s.error_level) ? pms_pkg::PMS_MODE_KERNEL : base;
    o.kernel_mode   = (o.eff_mode == pms_pkg::PMS_MODE_KERNEL);
    o.int_signal    = pend;
    o.ops64_ok      = (o.eff_mode != pms_pkg::PMS_MODE_USER) || s.ux;
    o.seg_wide_ok   = wide;
    if (s.exception_level) begin
      o.refill_vec  = pms_pkg::PMS_REFILL_GENERAL;
    end else if (wide) begin
      o.refill_vec  = pms_pkg::PMS_REFILL_EXTENDED;
    end else begin
      o.refill_vec  = pms_pkg::PMS_REFILL_ORDINARY;
    end
    o.exception_return_instr_to_error = s.error_level;
    o.ctx_update_en = !s.exception_level;
    o.kuseg_bypass  = s.error_level &&
                      (64'(probe_addr) < pms_pkg::PMS_KUSEG_BYPASS_BYTES);
    o.eic_mode      = external_interrupt_ctrl_mode;
    return o;
  endfunction : derive

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.st.bootstrap_vector_select     <= pms_pkg::PMS_BEV_RST;
      q.st.mm      <= pms_pkg::PMS_FLAG_RST;
      q.st.sr      <= pms_pkg::PMS_FLAG_RST;
      q.st.nmi     <= pms_pkg::PMS_FLAG_RST;
      q.st.hw_mask <= pms_pkg::PMS_HWM_RST;
      q.st.sw_mask <= pms_pkg::PMS_SWM_RST;
      q.st.mode    <= pms_pkg::PMS_MODE_RST;
      q.st.error_level     <= pms_pkg::PMS_ERL_RST;
      q.eic_mode   <= pms_pkg::PMS_CTL_RST;
      q.out.exception_return_instr_to_error <= 1'b1;
      q.out.kernel_mode   <= 1'b1;
      q.out.ctx_update_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign core_out = q.out;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bev_on_entry_a: assert property (
    core_ev.exc_take && (core_ev.exc_kind == pms_pkg::PMS_EXC_RESET ||
    core_ev.exc_kind == pms_pkg::PMS_EXC_SOFT ||
    core_ev.exc_kind == pms_pkg::PMS_EXC_NMI) |=> q.st.bootstrap_vector_select && q.st.error_level)
    else $error("bootstrap select not set on reset entry");

  match_flag_a: assert property (
    core_ev.multi_match |=> q.st.mm)
    else $error("multi-match flag not set");

  soft_flag_a: assert property (
    core_ev.exc_take && core_ev.exc_kind == pms_pkg::PMS_EXC_SOFT
    |=> stat_word[pms_pkg::PMS_SR_POS] && !stat_word[pms_pkg::PMS_NMI_POS])
    else $error("soft reset flag wrong");

  nmi_flag_a: assert property (
    core_ev.exc_take && core_ev.exc_kind == pms_pkg::PMS_EXC_NMI
    |=> !q.st.sr && q.st.nmi && q.out.exception_return_instr_to_error)
    else $error("nmi flag wrong");

  sw_mask_a: assert property (
    d.st.ie && !d.st.exception_level && !d.st.error_level && !d.eic_mode &&
    |(sw_int_req & d.st.sw_mask) |=> core_out.int_signal)
    else $error("enabled software request not signalled");

  prio_block_a: assert property (
    d.eic_mode && eic_level <= d.st.hw_mask |=> !core_out.int_signal)
    else $error("interrupt at or below priority level");

  exl_entry_a: assert property (
    core_ev.exc_take && core_ev.exc_kind == pms_pkg::PMS_EXC_GENERAL
    |=> q.st.exception_level && !core_out.ctx_update_en)
    else $error("exception level not set");

  level_block_a: assert property (
    (q.st.exception_level || q.st.error_level) |-> !core_out.int_signal &&
    core_out.kernel_mode)
    else $error("interrupt or user mode at raised level");

  ie_block_a: assert property (
    !q.st.ie |-> !core_out.int_signal)
    else $error("interrupt with master enable clear");

  di_clear_a: assert property (
    core_ev.di |=> !q.st.ie)
    else $error("disable instruction ignored");

endmodule : pms_status_core
`default_nettype wire
